/* appc_converter.sv */
// Active power path: dc blocker, phase match, multiply, smooth, pulses
//
// Overview of operation
// - Power is dc of current times voltage
// - High-pass removes current channel dc offset
// - Compensate blocker phase up to 1 kHz
// - Single-pole smoothing filter, 4.5 Hz corner
// - Accumulate power into pulse rate
// - Calibration pulses up to 2048 times faster
// - Slow outputs use long accumulation
// - 7 kHz bandwidth at 450 kHz clock
// - Oscillator clock drives all processing
// - Samples arrive as 24-bit words
// - Slow pulses active high
`timescale 1ns/100ps
module appc_converter #(
  parameter int unsigned SW = appc_pkg::SAMPLE_W,
  parameter int unsigned SLOW_SHIFT = 20,
  parameter int unsigned PULSE_LEN = appc_pkg::PULSE_CYCLES
) (
  input wire logic i_mclk, // Oscillator clock, one sample per edge
  input wire logic i_reset, // Sync reset, active high
  input wire logic signed [SW-1:0] i_current, // Current channel word
  input wire logic signed [SW-1:0] i_voltage, // Voltage channel word
  input wire logic [1:0] i_rate_sel, // Slow rate select
  input wire logic i_calib_scale, // Calibration scale select
  output logic o_slow_pulse_out_a, // Slow pulse A, active high
  output logic o_slow_pulse_out_b, // Slow pulse B, active high
  output logic o_calib_pulse_out, // Calibration pulse
  output logic signed [2*SW-1:0] o_active_power // Smoothed power
);
  // product and accumulators sized for full scale
  localparam int unsigned PW = 2 * SW;
  localparam int unsigned BW = SW + appc_pkg::BLOCK_SHIFT;
  localparam int unsigned FW = PW + appc_pkg::SMOOTH_SHIFT;

  typedef enum logic [1:0] {
    APPC_IDLE_TYPE = 2'b01,
    APPC_HIGH_TYPE = 2'b10
  } appc_pulse_type;

  // ------------------------------------------------------------
  // Current dc blocker and phase match
  // ------------------------------------------------------------
  logic signed [BW-1:0] dc_est_reg;
  logic signed [BW-1:0] dc_est_next;
  logic signed [SW:0] cur_blk_reg;
  logic signed [SW:0] cur_blk_next;
  logic signed [SW-1:0] volt_dly_reg;
  logic signed [SW-1:0] volt_dly_next;

  // every stage advances on each oscillator edge
  // no decimation, so the full band passes
  always_comb begin
    // leaky integrator tracks and removes dc
    dc_est_next = dc_est_reg + BW'(i_current)
      - (dc_est_reg >>> appc_pkg::BLOCK_SHIFT);
    cur_blk_next = (SW+1)'(i_current)
      - (SW+1)'(dc_est_reg >>> appc_pkg::BLOCK_SHIFT);
    // voltage delayed one stage to match current latency
    volt_dly_next = i_voltage;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dc_est_reg <= '0;
      cur_blk_reg <= '0;
      volt_dly_reg <= '0;
    end else begin
      dc_est_reg <= dc_est_next;
      cur_blk_reg <= cur_blk_next;
      volt_dly_reg <= volt_dly_next;
    end
  end

  // ------------------------------------------------------------
  // Multiplier and smoothing filter
  // ------------------------------------------------------------
  logic signed [PW:0] prod_reg;
  logic signed [PW:0] prod_next;
  logic signed [FW:0] smooth_reg;
  logic signed [FW:0] smooth_next;
  logic signed [PW-1:0] power_reg;
  logic signed [PW-1:0] power_next;

  always_comb begin
    prod_next = cur_blk_reg * volt_dly_reg;
    // one-pole smoothing, corner near 4.5 Hz
    smooth_next = smooth_reg + (FW+1)'(prod_reg)
      - (smooth_reg >>> appc_pkg::SMOOTH_SHIFT);
    power_next = PW'(smooth_reg >>> appc_pkg::SMOOTH_SHIFT);
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      prod_reg <= '0;
      smooth_reg <= '0;
      power_reg <= '0;
    end else begin
      prod_reg <= prod_next;
      smooth_reg <= smooth_next;
      power_reg <= power_next;
    end
  end

  // ------------------------------------------------------------
  // Digital-to-frequency conversion
  // ------------------------------------------------------------
  // Slow input scaled by rate select; calib input shifted further, both share one threshold
  logic signed [PW+15:0] slow_in;
  logic signed [PW+15:0] calib_in;
  logic [3:0] calib_shift;

  // calibration ratio from selects, up to 2048
  // Shift is rate select plus log2 of the ratio to the slow rate
  always_comb begin
    unique case ({i_rate_sel, i_calib_scale})
      3'b001: calib_shift = 4'h7;
      3'b000: calib_shift = 4'h6;
      3'b011: calib_shift = 4'h7;
      3'b010: calib_shift = 4'h6;
      3'b101: calib_shift = 4'h7;
      3'b100: calib_shift = 4'h6;
      3'b111: calib_shift = 4'h7;
      3'b110: calib_shift = 4'he;
    endcase
    // Widen before shifting so large shifts cannot wrap the sign
    slow_in = (PW + 16)'(power_reg) <<< i_rate_sel;
    calib_in = (PW + 16)'(power_reg) <<< calib_shift;
  end

  appc_acc_if #(.W(PW + 16)) slow_bus ();
  appc_acc_if #(.W(PW + 16)) calib_bus ();

  assign slow_bus.power = slow_in;
  assign slow_bus.sample_valid = 1'b1;
  assign calib_bus.power = calib_in;
  assign calib_bus.sample_valid = 1'b1;

  appc_pulse_acc #(.W(PW + 16), .SHIFT(SLOW_SHIFT + PW - 8)) u_slow (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .acc_bus(slow_bus)
  );

  // calibration pulses carry ripple; counter must average
  appc_pulse_acc #(.W(PW + 16), .SHIFT(SLOW_SHIFT + PW - 8)) u_calib (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .acc_bus(calib_bus)
  );

  // ------------------------------------------------------------
  // Slow pulse stretcher, A and B alternate
  // ------------------------------------------------------------
  appc_pulse_type st_reg;
  appc_pulse_type st_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic sel_b_reg;
  logic sel_b_next;
  logic out_a_reg;
  logic out_a_next;
  logic out_b_reg;
  logic out_b_next;
  logic calib_reg;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sel_b_next = sel_b_reg;
    out_a_next = 1'b0;
    out_b_next = 1'b0;
    unique case (st_reg)
      APPC_IDLE_TYPE: begin
        // A pulse during a stretch is dropped; rate is far too low
        if (slow_bus.pulse) begin
          st_next = APPC_HIGH_TYPE;
          cnt_next = 5'(PULSE_LEN - 1);
          out_a_next = !sel_b_reg;
          out_b_next = sel_b_reg;
        end
      end
      APPC_HIGH_TYPE: begin
        out_a_next = out_a_reg;
        out_b_next = out_b_reg;
        if (cnt_reg == appc_pkg::PULSE_CNT_RESET) begin
          st_next = APPC_IDLE_TYPE;
          out_a_next = 1'b0;
          out_b_next = 1'b0;
          sel_b_next = !sel_b_reg;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_reg <= APPC_IDLE_TYPE;
      cnt_reg <= appc_pkg::PULSE_CNT_RESET;
      sel_b_reg <= 1'b0;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      calib_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sel_b_reg <= sel_b_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      calib_reg <= calib_bus.pulse;
    end
  end

  assign o_slow_pulse_out_a = out_a_reg;
  assign o_slow_pulse_out_b = out_b_reg;
  assign o_calib_pulse_out = calib_reg;
  assign o_active_power = power_reg;

  a_slow_exclusive: assert property (@(posedge i_mclk) disable iff (i_reset)
    !(out_a_reg && out_b_reg))
    else $error("both slow outputs high");

  // stretch begins the cycle after accumulator pulse and holds at least two cycles
  a_slow_start: assert property (@(posedge i_mclk) disable iff (i_reset)
    (st_reg == APPC_IDLE_TYPE && slow_bus.pulse)
      |=> (out_a_reg || out_b_reg)[*2])
    else $error("slow pulse did not start");

  // product follows operands one cycle later
  a_mult_value: assert property (@(posedge i_mclk) disable iff (i_reset)
    ##1 prod_reg == (PW+1)'($past(cur_blk_reg) * $past(volt_dly_reg)))
    else $error("product mismatch");

  // zero input keeps the dc estimate decaying, never growing
  a_block_decay: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_current == '0 && dc_est_reg > 0) |=> dc_est_reg <= $past(dc_est_reg))
    else $error("dc estimate grew on zero input");

  a_smooth_out: assert property (@(posedge i_mclk) disable iff (i_reset)
    ##1 power_reg == PW'($past(smooth_reg) >>> appc_pkg::SMOOTH_SHIFT))
    else $error("smoothed power mismatch");

  // voltage aligned with blocked current
  // Edge after release still shows the cleared stage, so skip it
  a_volt_align: assert property (@(posedge i_mclk) disable iff (i_reset)
    !$past(i_reset) |-> volt_dly_reg == $past(i_voltage))
    else $error("voltage delay wrong");
endmodule

/* appc_pkg.sv */
// Constants and types shared by the active power to pulse converter
package appc_pkg;
  // Converter word width and oscillator rate
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned OSC_HZ = 450000;
  localparam int unsigned BANDWIDTH_HZ = 7000;
  localparam int unsigned PHASE_MATCH_HZ = 1000;
  // Filter coefficients as right shifts
  // Smoothing corner 4.5 Hz at 450 kHz: 2*pi*4.5/450000 ~ 2^-14
  localparam int unsigned SMOOTH_SHIFT = 14;
  // Dc blocker corner well below line frequency
  localparam int unsigned BLOCK_SHIFT = 16;
  // Accumulation thresholds as powers of two
  localparam int unsigned SLOW_SHIFT_BASE = 15;
  localparam int unsigned CALIB_RATIO_MAX = 2048;
  // Slow pulse width in cycles
  localparam int unsigned PULSE_CYCLES = 16;
  localparam logic [4:0] PULSE_CNT_RESET = 5'h00;
endpackage

/* appc_acc_if.sv */
// Accumulator link between converter core and pulse generator
`timescale 1ns/100ps
interface appc_acc_if #(
  parameter int unsigned W = 48
);
  logic signed [W-1:0] power;
  logic sample_valid;
  logic pulse;
  modport src (output power, output sample_valid, input pulse);
  modport acc (input power, input sample_valid, output pulse);
endinterface

/* appc_pulse_acc.sv */
// Digital-to-frequency accumulator producing one pulse per threshold
`timescale 1ns/100ps
module appc_pulse_acc #(
  parameter int unsigned W = 48,
  parameter int unsigned SHIFT = 20
) (
  input wire logic i_mclk, // Clock
  input wire logic i_reset, // Sync reset
  appc_acc_if.acc acc_bus // Power in, pulse out
);
  localparam logic signed [W:0] THRESH = (W+1)'(1) <<< SHIFT;

  logic signed [W:0] acc_reg;
  logic signed [W:0] acc_next;
  logic pulse_reg;
  logic pulse_next;

  always_comb begin
    acc_next = acc_reg;
    pulse_next = 1'b0;
    if (acc_bus.sample_valid) begin
      acc_next = acc_reg + (W+1)'(acc_bus.power);
      // Negative power never pulses; floor at zero to avoid creep
      if (acc_next < 0) begin
        acc_next = '0;
      end
      if (acc_next > THRESH) begin
        acc_next = acc_next - THRESH;
        pulse_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      acc_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      pulse_reg <= pulse_next;
    end
  end

  assign acc_bus.pulse = pulse_reg;

  a_acc_bounded: assert property (@(posedge i_mclk) disable iff (i_reset)
    acc_reg <= THRESH)
    else $error("accumulator exceeded threshold");

  // pulse only after a valid sample
  a_pulse_cause: assert property (@(posedge i_mclk) disable iff (i_reset)
    pulse_reg |-> $past(acc_bus.sample_valid))
    else $error("pulse without sample");
endmodule

/* appc_pulse_counter.sv */
// Pulse counter model standing at the converter's pulse outputs
`timescale 1ns/100ps
module appc_pulse_counter #(
  parameter int unsigned PULSE_LEN = 16
) (
  input wire logic i_mclk, // Clock
  input wire logic i_reset, // Clears counts
  input wire logic i_slow_a, // Slow pulse A
  input wire logic i_slow_b, // Slow pulse B
  input wire logic i_calib, // Calibration pulse
  output int o_cnt_a, // Pulses seen on A
  output int o_cnt_b, // Pulses seen on B
  output int o_cnt_calib, // Calibration pulses in window
  output int o_bad // Shape or order faults
);
  logic a_d, b_d, c_d, last_a;
  int wid;
  always @(posedge i_mclk) begin
    a_d <= i_slow_a;
    b_d <= i_slow_b;
    c_d <= i_calib;
    if (i_reset) begin
      o_cnt_a <= 0;
      o_cnt_b <= 0;
      o_cnt_calib <= 0;
      o_bad <= 0;
      wid <= 0;
      last_a <= 1'b0;
    end else begin
      if (i_slow_a || i_slow_b) wid <= wid + 1;
      if ((a_d && !i_slow_a) || (b_d && !i_slow_b)) begin
        if (wid != PULSE_LEN) o_bad <= o_bad + 1;
        wid <= (i_slow_a || i_slow_b) ? 1 : 0;
      end
      if (i_slow_a && !a_d) begin
        o_cnt_a <= o_cnt_a + 1;
        if (last_a) o_bad <= o_bad + 1;
        last_a <= 1'b1;
      end
      if (i_slow_b && !b_d) begin
        o_cnt_b <= o_cnt_b + 1;
        if (!last_a) o_bad <= o_bad + 1;
        last_a <= 1'b0;
      end
      if (i_slow_a && i_slow_b) o_bad <= o_bad + 1;
      if (i_calib && c_d) o_bad <= o_bad + 1;
      if (i_calib && !c_d) o_cnt_calib <= o_cnt_calib + 1;
    end
  end
endmodule

/* tb_active_power_to_pulse_converter.sv */
// Self-checking bench for the active power to pulse converter
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  num_errors++; $display("wrong value at %0t: line %0d got %0h exp %0h", \
  $time, `__LINE__, got, exp); end end
module tb_active_power_to_pulse_converter;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic signed [23:0] i_current = 24'sh000000;
  logic signed [23:0] i_voltage = 24'sh000000;
  logic signed [23:0] amp_i = 24'sh000000;
  logic signed [23:0] amp_v = 24'sh000000;
  logic [1:0] i_rate_sel = 2'h0;
  logic i_calib_scale = 1'b0;
  logic [3:0] ph = 4'h0;
  logic sa, sb, cp;
  logic signed [47:0] pwr;
  int cnt_a, cnt_b, cnt_c, bad;
  int num_errors = 0;
  int compares = 0;
  int cal [6];
  always #5 i_mclk = ~i_mclk;
  // Square waves so the dc blocker passes them
  always @(posedge i_mclk) begin
    ph <= ph + 4'h1;
    i_current <= ph[3] ? amp_i : -amp_i;
    i_voltage <= ph[3] ? amp_v : -amp_v;
  end
  appc_converter #(.SLOW_SHIFT(4)) dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_current(i_current),
    .i_voltage(i_voltage), .i_rate_sel(i_rate_sel),
    .i_calib_scale(i_calib_scale), .o_slow_pulse_out_a(sa),
    .o_slow_pulse_out_b(sb), .o_calib_pulse_out(cp), .o_active_power(pwr));
  appc_pulse_counter #(.PULSE_LEN(appc_pkg::PULSE_CYCLES)) far (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_slow_a(sa), .i_slow_b(sb),
    .i_calib(cp), .o_cnt_a(cnt_a), .o_cnt_b(cnt_b), .o_cnt_calib(cnt_c),
    .o_bad(bad));
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Fresh start with given settings, then stream n cycles
  task automatic run(int n, logic [1:0] rs, logic sc,
                     logic signed [23:0] ai, logic signed [23:0] av);
    @(posedge i_mclk);
    i_reset <= 1'b1;
    i_rate_sel <= rs;
    i_calib_scale <= sc;
    amp_i <= ai;
    amp_v <= av;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic t_reset();
    repeat (12) @(posedge i_mclk);
    #1;
    `CHK({sa, sb, cp}, 3'h0)
    `CHK(pwr, 48'sh0)
    @(posedge i_mclk);
    i_reset <= 1'b0;
    $display("test reset done");
  endtask
  task automatic t_idle();
    run(300, 2'h3, 1'b0, 24'sh000000, 24'sh000000);
    `CHK(pwr, 48'sh0)
    `CHK(cnt_a + cnt_b + cnt_c, 0)
    $display("test idle done");
  endtask
  task automatic t_inphase();
    int s;
    // Amplitude kept low so calibration pulses stay apart
    run(20000, 2'h3, 1'b1, 24'sh020000, 24'sh020000);
    s = 16 * (cnt_a + cnt_b);
    `CHK(pwr > 0, 1'b1)
    // Full scale 2^34; a 2^14-cycle time constant leaves about 0.70
    `CHK(pwr inside {[48'sh2c0000000 : 48'sh2e0000000]}, 1'b1)
    `CHK(cnt_a > 0, 1'b1)
    `CHK(cnt_b > 0, 1'b1)
    `CHK((cnt_a - cnt_b) inside {0, 1}, 1'b1)
    `CHK(cnt_c > cnt_a, 1'b1)
    // Mode 3'b111 gives sixteen calibration pulses per slow pulse
    `CHK(cnt_c inside {[s - 1 : s + 31]}, 1'b1)
    `CHK(bad, 0)
    $display("test in phase done");
  endtask
  task automatic t_antiphase();
    run(20000, 2'h3, 1'b0, 24'sh200000, -24'sh200000);
    `CHK(pwr < 0, 1'b1)
    `CHK(cnt_a + cnt_b + cnt_c, 0)
    $display("test anti phase done");
  endtask
  task automatic t_ratio();
    // Modes as {rate_sel, calib_scale}; the fastest two at low amplitude
    logic [2:0] mode [6] = '{3'h0, 3'h1, 3'h6, 3'h7, 3'h2, 3'h3};
    logic signed [23:0] amp;
    for (int k = 0; k < 6; k++) begin
      amp = (k == 2 || k == 3) ? 24'sh002000 : 24'sh020000;
      run(6000, mode[k][2:1], mode[k][0], amp, amp);
      cal[k] = cnt_c;
      `CHK(bad, 0)
    end
    // Ratio 128 against 64 at the slowest rate
    `CHK((cal[1] - 2 * cal[0]) inside {[-2 : 3]}, 1'b1)
    // 2048 at 2^-8 of the power matches 64 at full power
    `CHK((cal[2] - cal[0]) inside {[-2 : 2]}, 1'b1)
    `CHK(cal[2] > cal[3], 1'b1)
    // Calibration rate follows calib_scale, not the slow rate select, except in mode 3'b110
    `CHK((cal[4] - cal[0]) inside {[-2 : 2]}, 1'b1)
    `CHK((cal[5] - cal[1]) inside {[-2 : 2]}, 1'b1)
    $display("test calibration ratio done");
  endtask
  initial begin
    repeat (90000) @(posedge i_mclk);
    num_errors++;
    close_out();
  end
  initial begin
    t_reset();
    t_idle();
    t_inphase();
    t_antiphase();
    t_ratio();
    close_out();
  end
endmodule
